// File: rtl/fbmc_regs.vh
// Register map, field positions and timing counts of the flash boot and mode control block
`ifndef FBMC_REGS_VH
`define FBMC_REGS_VH
// ****************************************
// Register byte addresses
// ****************************************
`define FBMC_ADDR_PDC    12'h000
`define FBMC_ADDR_GATE   12'h004
`define FBMC_ADDR_CTL1   12'h008
`define FBMC_ADDR_CTL2   12'h00C
`define FBMC_ADDR_EBS    12'h010
`define FBMC_ADDR_STAT   12'h014
// ****************************************
// Fields and reset values
// ****************************************
`define FBMC_CTRL_BIT    7
`define FBMC_BYTE_RST    8'h00
`define FBMC_STAT_DIV    31:16
// ****************************************
// Modes
// ****************************************
`define FBMC_MODE_NONE   2'h0
`define FBMC_MODE_USER   2'h1
`define FBMC_MODE_BOOT   2'h2
`define FBMC_MODE_PROG   2'h3
// ****************************************
// Boot loader constants
// ****************************************
`define FBMC_READY_STATES 16'h0064
`define FBMC_LOW_BITS_M1 4'h8
`define FBMC_CAL_BYTE    8'h00
`define FBMC_ACK_BYTE    8'h55
`define FBMC_RAM_BASE    16'hF780
`define FBMC_RAM_LAST    16'hFEEF
`define FBMC_RAM_DEPTH   (`FBMC_RAM_LAST - `FBMC_RAM_BASE + 1)
`define FBMC_RAM_LEN     11'h770
`define FBMC_UART_BITS   4'hA
`endif

// File: rtl/fbmc_uart.v
// Asynchronous serial port, 8 data bits, 1 stop bit, no parity
`timescale 1ns/1ps
`default_nettype none
`include "fbmc_regs.vh"
module fbmc_uart (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        ce,
	input  wire [15:0] divisor,
	input  wire        rx_en,
	input  wire        tx_en,
	input  wire        rxd,
	input  wire        tx_start,
	input  wire [7:0]  tx_data,
	output reg         txd_r,
	output wire        tx_busy,
	output reg         rx_valid_r,
	output reg  [7:0]  rx_data_r,
	output reg         rx_err_r
);
	// ****************************************
	// Transmitter
	// ****************************************
	reg [9:0]  tx_shift_r;   // Frame, LSB on the line
	reg [3:0]  tx_bits_r;    // Bits still to send
	reg [15:0] tx_cnt_r;     // Cycles left in bit
	assign tx_busy = (tx_bits_r != 4'h0);

	// Shift out start, data, stop; idle line stays high
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_shift_r <= 10'h3FF;
			tx_bits_r  <= 4'h0;
			tx_cnt_r   <= 16'h0000;
			txd_r      <= 1'b1;
		end else if (ce) begin
			if (!tx_en) begin
				// Disabled: abort and hold mark level
				tx_shift_r <= 10'h3FF;
				tx_bits_r  <= 4'h0;
				txd_r      <= 1'b1;
			end else begin
				txd_r <= tx_shift_r[0];
				if (!tx_busy && tx_start) begin
					tx_shift_r <= {1'b1, tx_data, 1'b0}; // R7
					tx_bits_r  <= `FBMC_UART_BITS;
					tx_cnt_r   <= divisor;
				end else if (tx_busy) begin
					if (tx_cnt_r <= 16'h0001) begin
						tx_shift_r <= {1'b1, tx_shift_r[9:1]};
						tx_bits_r  <= tx_bits_r - 4'h1;
						tx_cnt_r   <= divisor;
					end else begin
						tx_cnt_r <= tx_cnt_r - 16'h0001;
					end
				end
			end
		end
	end

	// ****************************************
	// Receiver
	// ****************************************
	reg [8:0]  rx_sh_r;      // Sampled bits, newest on top
	reg [3:0]  rx_bits_r;    // Samples still to take
	reg [15:0] rx_cnt_r;     // Cycles to next sample

	// Sample mid-bit from the start edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_sh_r    <= 9'h000;
			rx_bits_r  <= 4'h0;
			rx_cnt_r   <= 16'h0000;
			rx_valid_r <= 1'b0;
			rx_data_r  <= 8'h00;
			rx_err_r   <= 1'b0;
		end else if (ce) begin
			rx_valid_r <= 1'b0;
			if (!rx_en) begin
				rx_bits_r <= 4'h0;
			end else if (rx_bits_r == 4'h0) begin
				// Idle: wait for a start edge
				if (!rxd) begin
					rx_bits_r <= `FBMC_UART_BITS;
					rx_cnt_r  <= {1'b0, divisor[15:1]};
				end
			end else if (rx_cnt_r == 16'h0000) begin
				rx_sh_r   <= {rxd, rx_sh_r[8:1]};
				rx_bits_r <= rx_bits_r - 4'h1;
				rx_cnt_r  <= divisor - 16'h0001;
				if (rx_bits_r == 4'h1) begin
					// Stop bit sample ends the frame
					rx_valid_r <= 1'b1; // R7
					rx_data_r  <= rx_sh_r[8:1];
					rx_err_r   <= ~rxd;
				end
			end else begin
				rx_cnt_r <= rx_cnt_r - 16'h0001;
			end
		end
	end
endmodule // fbmc_uart
`default_nettype wire

// File: rtl/fbmc_top.v
// Flash boot and mode control: registers, strap decode and serial boot loader
`timescale 1ns/1ps
`default_nettype none
`include "fbmc_regs.vh"
// Behaviour
// [R1] Subactive powers flash down unless inhibit set
// [R2] Reserved bits 6..0 read zero
// [R3] Control registers reachable only with access enable
// [R4] Straps select user, boot or programmer mode
// [R5] Straps stable four states before reset release
// [R6] Boot loads program, erases flash, runs it
// [R7] Serial frames 8 data, 1 stop, no parity
// [R8] Measure host low period, match bit rate
// [R9] Ready to measure 100 states after reset
// [R10] Send 00 after matching, await host 55
// [R11] Host resets device on bad indication
// [R12] Host bit rate suits system clock
// [R13] Program lands F780..FEEF, locked until handover
// [R14] Disable serial, keep divisor, transmit high
// [R15] Control program initialises its registers
// [R16] Reset low 20 states leaves boot mode
// [R17] Watchdog overflow ends boot mode
// [R18] Test and interrupt pins steady in boot
// [R19] Program and erase code runs from RAM
// [R20] Gated registers ignore writes, read zero
module fbmc_top (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        ce,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata_r,
	output wire        pready,
	output wire        pslverr,
	input  wire        test_pin,
	input  wire        nonmaskable_interrupt_pin,
	input  wire        port8_bit5_strap,
	input  wire [2:0]  portb_strap_bits,
	input  wire        subactive_mode,
	output wire        flash_power_down,
	input  wire [7:0]  flash_control_two,
	output wire [7:0]  flash_control_one,
	output wire [7:0]  erase_block_select,
	input  wire        overflow_watchdog,
	input  wire        serial_receive_pin,
	output wire        serial_transmit_pin,
	output wire        flash_erase_all_req,
	input  wire        flash_erase_done,
	output wire [1:0]  mode_sel,
	output wire        boot_ram_locked,
	output wire        exec_start,
	output wire        rx_enable_bit,
	output wire        tx_on_bit,
	output wire [15:0] baud_divisor_reg,
	input  wire [10:0] ram_rd_addr,
	output reg  [7:0]  ram_rd_data_r
);
	// ****************************************
	// Boot loader states
	// ****************************************
	localparam [10:0] S_IDLE  = 11'h001; // Not in boot mode
	localparam [10:0] S_WAIT  = 11'h002; // Post-reset settle
	localparam [10:0] S_ARM   = 11'h004; // Wait line high
	localparam [10:0] S_MEAS  = 11'h008; // Count low period
	localparam [10:0] S_SEND  = 11'h010; // Send indication
	localparam [10:0] S_ACK   = 11'h020; // Await host reply
	localparam [10:0] S_LENH  = 11'h040; // Length high byte
	localparam [10:0] S_LENL  = 11'h080; // Length low byte
	localparam [10:0] S_LOAD  = 11'h100; // Bytes into RAM
	localparam [10:0] S_ERASE = 11'h200; // Whole-flash erase
	localparam [10:0] S_RUN   = 11'h400; // Handed over

	// ****************************************
	// Storage
	// ****************************************
	reg [7:0]  pdc_r;        // Power-down control
	reg [7:0]  gate_r;       // Access gate
	reg [7:0]  ctl1_r;       // Flash control one
	reg [7:0]  ebs_r;        // Erase block select
	reg [1:0]  mode_r;       // Decoded mode
	reg        taken_r;      // Straps captured
	reg [10:0] state_r;      // Loader state
	reg [10:0] state_nxt;
	reg [15:0] wait_r;       // Settle counter
	reg [3:0]  presc_r;      // Low period prescaler
	reg [15:0] div_r;        // Cycles per bit
	reg [10:0] len_r;        // Bytes left to load
	reg [10:0] wptr_r;       // RAM write pointer
	reg        sent_r;       // Indication issued
	reg [7:0]  mem [0:`FBMC_RAM_DEPTH-1]; // Control program RAM
	wire       tx_busy;
	wire       rx_valid;
	wire [7:0] rx_data;
	wire       rx_err;
	wire       ser_en;

	// ****************************************
	// APB slave
	// ****************************************
	wire gate_on = gate_r[`FBMC_CTRL_BIT];
	wire a_pdc   = (paddr == `FBMC_ADDR_PDC);
	wire a_gate  = (paddr == `FBMC_ADDR_GATE);
	wire a_ctl1  = (paddr == `FBMC_ADDR_CTL1);
	wire a_ctl2  = (paddr == `FBMC_ADDR_CTL2);
	wire a_ebs   = (paddr == `FBMC_ADDR_EBS);
	wire a_stat  = (paddr == `FBMC_ADDR_STAT);
	wire mapped  = a_pdc | a_gate | a_ctl1 | a_ctl2 | a_ebs | a_stat;
	wire wr_acc  = psel & penable & pwrite & ce;
	wire gated_ok = gate_on; // R3
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// Register writes; gated ones dropped while disabled
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pdc_r  <= `FBMC_BYTE_RST;
			gate_r <= `FBMC_BYTE_RST;
			ctl1_r <= `FBMC_BYTE_RST;
			ebs_r  <= `FBMC_BYTE_RST;
		end else if (wr_acc) begin
			if (a_gate)
				gate_r <= {pwdata[`FBMC_CTRL_BIT], 7'h00}; // R2
			if (a_pdc && gated_ok)
				pdc_r <= {pwdata[`FBMC_CTRL_BIT], 7'h00}; // R20
			if (a_ctl1 && gated_ok)
				ctl1_r <= pwdata[7:0]; // R20
			if (a_ebs && gated_ok)
				ebs_r <= pwdata[7:0]; // R20
		end
	end

	// Read data captured in the setup cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h00000000;
		end else if (ce && psel && !penable) begin
			prdata_r <= 32'h00000000;
			if (a_gate)
				prdata_r <= {24'h000000, gate_r}; // R2
			else if (a_stat)
				prdata_r <= {div_r, 12'h000, exec_start, boot_ram_locked, mode_r};
			else if (gated_ok) begin
				// Gated window reads zero while closed
				if (a_pdc)
					prdata_r <= {24'h000000, pdc_r}; // R20
				else if (a_ctl1)
					prdata_r <= {24'h000000, ctl1_r};
				else if (a_ctl2)
					prdata_r <= {24'h000000, flash_control_two};
				else if (a_ebs)
					prdata_r <= {24'h000000, ebs_r};
			end
		end
	end

	// ****************************************
	// Power-down and control outputs
	// ****************************************
	assign flash_power_down = subactive_mode & ~pdc_r[`FBMC_CTRL_BIT]; // R1
	assign flash_control_one = ctl1_r;
	assign erase_block_select = ebs_r;

	// ****************************************
	// Strap decode
	// ****************************************
	// Caught on the first enabled edge after release; straps settled before
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r  <= `FBMC_MODE_NONE;
			taken_r <= 1'b0;
		end else if (ce) begin
			if (!taken_r) begin
				taken_r <= 1'b1; // R5
				if (!test_pin && nonmaskable_interrupt_pin)
					mode_r <= `FBMC_MODE_USER; // R4
				else if (!test_pin && port8_bit5_strap)
					mode_r <= `FBMC_MODE_BOOT; // R4
				else if (test_pin && portb_strap_bits == 3'h0)
					mode_r <= `FBMC_MODE_PROG; // R4
				else
					mode_r <= `FBMC_MODE_NONE;
			end else if (overflow_watchdog && mode_r == `FBMC_MODE_BOOT) begin
				mode_r <= `FBMC_MODE_NONE; // R17
			end
		end
	end
	assign mode_sel = mode_r;

	// ****************************************
	// Boot loader sequence
	// ****************************************
	// Next state
	always @* begin
		state_nxt = state_r;
		case (state_r)
			S_IDLE:
				if (mode_r == `FBMC_MODE_BOOT)
					state_nxt = S_WAIT;
			S_WAIT:
				if (wait_r >= `FBMC_READY_STATES - 16'h0001)
					state_nxt = S_ARM; // R9
			S_ARM:
				if (serial_receive_pin)
					state_nxt = S_MEAS;
			S_MEAS:
				if (serial_receive_pin && div_r != 16'h0000)
					state_nxt = S_SEND; // R8
			S_SEND:
				if (sent_r && !tx_busy)
					state_nxt = S_ACK;
			S_ACK:
				if (rx_valid && !rx_err && rx_data == `FBMC_ACK_BYTE)
					state_nxt = S_LENH; // R10
			S_LENH:
				if (rx_valid)
					state_nxt = S_LENL;
			S_LENL:
				if (rx_valid)
					state_nxt = S_LOAD;
			S_LOAD:
				if (len_r == 11'h000)
					state_nxt = S_ERASE; // R6
			S_ERASE:
				if (flash_erase_done)
					state_nxt = S_RUN; // R6
			S_RUN:
				state_nxt = S_RUN;
			default:
				state_nxt = S_IDLE;
		endcase
		if (overflow_watchdog)
			state_nxt = S_IDLE; // R17
	end

	// State, counters and measured divisor
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= S_IDLE; // R16
			wait_r  <= 16'h0000;
			presc_r <= 4'h0;
			div_r   <= 16'h0000;
			len_r   <= 11'h000;
			wptr_r  <= 11'h000;
			sent_r  <= 1'b0;
		end else if (ce) begin
			state_r <= state_nxt;
			case (state_r)
				S_WAIT:
					wait_r <= wait_r + 16'h0001;
				S_MEAS:
					// Nine low bit times per calibration byte
					if (!serial_receive_pin) begin
						if (presc_r == `FBMC_LOW_BITS_M1) begin
							presc_r <= 4'h0;
							div_r   <= div_r + 16'h0001; // R8
						end else begin
							presc_r <= presc_r + 4'h1;
						end
					end
				S_SEND:
					sent_r <= 1'b1; // R10
				S_LENH:
					if (rx_valid)
						len_r <= {rx_data[2:0], 8'h00};
				S_LENL:
					if (rx_valid) begin
						// Clamp to the load area
						if ({len_r[10:8], rx_data} > `FBMC_RAM_LEN)
							len_r <= `FBMC_RAM_LEN; // R13
						else
							len_r <= {len_r[10:8], rx_data};
					end
				S_LOAD:
					if (rx_valid && len_r != 11'h000) begin
						wptr_r <= wptr_r + 11'h001;
						len_r  <= len_r - 11'h001;
					end
				default: ;
			endcase
		end
	end

	// Program bytes into the load area
	always @(posedge pclk) begin
		if (ce && state_r == S_LOAD && rx_valid && len_r != 11'h000)
			mem[wptr_r] <= rx_data; // R13
	end

	// RAM readable only after handover
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ram_rd_data_r <= 8'h00;
		else if (ce)
			ram_rd_data_r <= (state_r == S_RUN && ram_rd_addr < `FBMC_RAM_LEN) ?
				mem[ram_rd_addr] : 8'h00; // R19
	end

	// ****************************************
	// Serial port and handover outputs
	// ****************************************
	assign ser_en = (state_r == S_SEND) | (state_r == S_ACK) | (state_r == S_LENH) |
		(state_r == S_LENL) | (state_r == S_LOAD);
	assign rx_enable_bit       = ser_en; // R14
	assign tx_on_bit           = ser_en; // R14
	assign baud_divisor_reg    = div_r;  // R14
	assign flash_erase_all_req = (state_r == S_ERASE);
	assign exec_start          = (state_r == S_RUN);
	assign boot_ram_locked     = (mode_r == `FBMC_MODE_BOOT) & ~exec_start; // R13

	fbmc_uart u_uart (
		.pclk       (pclk),
		.presetn    (presetn),
		.ce         (ce),
		.divisor    (div_r),
		.rx_en      (ser_en),
		.tx_en      (ser_en),
		.rxd        (serial_receive_pin),
		.tx_start   (state_r == S_SEND && !sent_r),
		.tx_data    (`FBMC_CAL_BYTE),
		.txd_r      (serial_transmit_pin),
		.tx_busy    (tx_busy),
		.rx_valid_r (rx_valid),
		.rx_data_r  (rx_data),
		.rx_err_r   (rx_err)
	);
endmodule // fbmc_top
`default_nettype wire

// File: bench/fbmc_top_checker.sv
// Port assertions for the flash boot and mode control block
`timescale 1ns/1ps
`default_nettype none
module fbmc_top_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        ce,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata_r,
	input wire logic        test_pin,
	input wire logic        nonmaskable_interrupt_pin,
	input wire logic        port8_bit5_strap,
	input wire logic [2:0]  portb_strap_bits,
	input wire logic        subactive_mode,
	input wire logic        flash_power_down,
	input wire logic        overflow_watchdog,
	input wire logic        serial_transmit_pin,
	input wire logic        flash_erase_all_req,
	input wire logic        flash_erase_done,
	input wire logic [1:0]  mode_sel,
	input wire logic        boot_ram_locked,
	input wire logic        exec_start,
	input wire logic        rx_enable_bit,
	input wire logic        tx_on_bit,
	input wire logic [15:0] baud_divisor_reg,
	input wire logic [7:0]  ram_rd_data_r
);
	// ****
	// Shadow state
	// ****
	logic       gate_r;      // Access gate copy
	logic       inhib_r;     // Power-down inhibit copy
	logic       erased_r;    // Erase handshake seen
	logic [1:0] strap_mode;  // Mode the straps ask for
	wire  logic wr_acc = psel & penable & pwrite & ce;
	wire  logic rd_acc = psel & penable & !pwrite;
	// Strap decode
	assign strap_mode = !test_pin ? (nonmaskable_interrupt_pin ? 2'h1 :
		(port8_bit5_strap ? 2'h2 : 2'h0)) : (portb_strap_bits == 3'h0 ? 2'h3 : 2'h0);
	// Follow bus writes and the erase handshake
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_r <= 1'b0;
			inhib_r <= 1'b0;
			erased_r <= 1'b0;
		end else begin
			if (wr_acc && paddr == 12'h004) gate_r <= pwdata[7];
			if (wr_acc && paddr == 12'h000 && gate_r) inhib_r <= pwdata[7];
			if (flash_erase_all_req && flash_erase_done) erased_r <= 1'b1;
		end
	end
	// ****
	// Assertions
	// ****
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence handed_s;
		$rose(exec_start);
	endsequence
	sequence held_s;
		exec_start ##1 exec_start;
	endsequence
	pwr_down_a: assert property (flash_power_down == (subactive_mode & ~inhib_r))
		else $error("power-down output wrong");
	rsv_zero_a: assert property (rd_acc && paddr < 12'h008 |-> prdata_r[6:0] == 7'h00)
		else $error("reserved bits not zero");
	gate_read_a: assert property (rd_acc && !gate_r && (paddr == 12'h008 ||
		paddr == 12'h00C || paddr == 12'h010 || paddr == 12'h000) |-> prdata_r == 32'h0)
		else $error("gated read not zero");
	strap_mode_a: assert property ($rose(presetn) |=> mode_sel == $past(strap_mode))
		else $error("strap mode wrong");
	wdog_end_a: assert property (overflow_watchdog |=> mode_sel == 2'h0)
		else $error("watchdog left mode set");
	hand_over_a: assert property (handed_s |-> !rx_enable_bit && !tx_on_bit
		&& serial_transmit_pin && !boot_ram_locked)
		else $error("hand-over state wrong");
	div_keep_a: assert property (held_s |-> $stable(baud_divisor_reg))
		else $error("divisor changed after hand-over");
	erase_first_a: assert property (handed_s |-> erased_r)
		else $error("ran before erase");
	idle_tx_a: assert property (!tx_on_bit |-> serial_transmit_pin)
		else $error("transmit not idle high");
	ram_lock_a: assert property (boot_ram_locked ##1 boot_ram_locked |-> ram_rd_data_r == 8'h00)
		else $error("locked RAM visible");
endmodule // fbmc_top_checker
bind fbmc_top fbmc_top_checker fbmc_top_checker_i (.pclk, .presetn, .ce, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata_r, .test_pin, .nonmaskable_interrupt_pin,
	.port8_bit5_strap, .portb_strap_bits, .subactive_mode, .flash_power_down,
	.overflow_watchdog, .serial_transmit_pin, .flash_erase_all_req, .flash_erase_done,
	.mode_sel, .boot_ram_locked, .exec_start, .rx_enable_bit, .tx_on_bit,
	.baud_divisor_reg, .ram_rd_data_r);
`default_nettype wire

// File: bench/fbmc_host_model.sv
// Host side of the boot serial link
`timescale 1ns/1ps
`default_nettype none
module fbmc_host_model #(
	parameter int BIT = 64  // Clocks per bit, a rate the clock can match
) (
	input wire logic pclk,
	input wire logic dev_txd,
	output var logic host_txd
);
	int         n_rx = 0;         // Frames taken from the device
	logic [7:0] rx_byte = 8'h00;  // Last frame taken
	// Line idles high, also across reset release
	initial begin
		host_txd = 1'b1;
	end
	// One frame: start, 8 data LSB first, 1 stop, no parity
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			host_txd <= f[i];
			repeat (BIT) @(posedge pclk);
		end
	endtask
	// Take device frames at mid-bit
	always begin
		@(negedge dev_txd);
		repeat (BIT / 2) @(posedge pclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge pclk);
			rx_byte[i] = dev_txd;
		end
		repeat (BIT) @(posedge pclk);
		n_rx++;
	end
endmodule // fbmc_host_model
`default_nettype wire

// File: bench/fbmc_top_tb.sv
// Self-checking bench for the flash boot and mode control block
`timescale 1ns/1ps
`default_nettype none
module fbmc_top_tb;
	localparam int BIT = 64;  // Host bit period in clocks
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        ce = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [5:0]  strap = 6'h1C;   // Test, interrupt, port8, portb
	logic        sub = 1'b0;
	logic        wdog = 1'b0;
	logic        edone = 1'b0;
	logic [10:0] raddr = 11'h000;
	logic [31:0] prdata_r;
	logic [15:0] baud;
	logic [7:0]  ram_q;
	logic [1:0]  mode_sel;
	logic        pready, pslverr, flash_pd, rxd, txd, erase_req;
	logic        locked, exec_start, rx_en, tx_on;
	logic [7:0]  ctl1_q, ebs_q;   // Flash control one, erase block select
	logic        err_q = 1'b0;    // Error flag of the last transfer
	int          num_errors = 0;
	int          n_checks = 0;
	always #4 pclk = ~pclk;
	fbmc_top fbmc_top_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata_r(prdata_r), .pready(pready), .pslverr(pslverr), .test_pin(strap[5]),
		.nonmaskable_interrupt_pin(strap[4]), .port8_bit5_strap(strap[3]),
		.portb_strap_bits(strap[2:0]), .subactive_mode(sub), .flash_power_down(flash_pd),
		.flash_control_two(8'h3C), .flash_control_one(ctl1_q), .erase_block_select(ebs_q),
		.overflow_watchdog(wdog), .serial_receive_pin(rxd), .serial_transmit_pin(txd),
		.flash_erase_all_req(erase_req), .flash_erase_done(edone), .mode_sel(mode_sel),
		.boot_ram_locked(locked), .exec_start(exec_start), .rx_enable_bit(rx_en),
		.tx_on_bit(tx_on), .baud_divisor_reg(baud), .ram_rd_addr(raddr),
		.ram_rd_data_r(ram_q));
	fbmc_host_model #(.BIT(BIT)) fbmc_host_model_i (.pclk(pclk), .dev_txd(txd),
		.host_txd(rxd));
	// ****
	// Helpers
	// ****
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic give_up;
		num_errors++;
		complete_run;
	endtask
	// One APB transfer, request held until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int t;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1 && t < 50);
		r = prdata_r;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (t >= 50) give_up;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] r;
		apb(1'b0, a, 32'h0, r);
		check(r, e);
	endtask
	// Straps are set half a cycle before reset falls
	task automatic do_reset(input int n);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (n) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_regs;
		// Clock enable low: the gate write must not land
		ce <= 1'b0;
		wr(12'h004, 32'h80);
		ce <= 1'b1;
		rdc(12'h004, 32'h0);
		wr(12'h008, 32'hFF);
		rdc(12'h008, 32'h0);
		check(ctl1_q, 32'h0);
		wr(12'h004, 32'hFFFFFFFF);
		rdc(12'h004, 32'h80);
		rdc(12'h008, 32'h0);
		wr(12'h008, 32'hA5);
		rdc(12'h008, 32'hA5);
		check(ctl1_q, 32'hA5);
		wr(12'h010, 32'h5A);
		rdc(12'h010, 32'h5A);
		check(ebs_q, 32'h5A);
		rdc(12'h00C, 32'h3C);
		wr(12'h004, 32'h0);
		rdc(12'h00C, 32'h0);
		check(err_q, 32'h0);
		rdc(12'h020, 32'h0);
		check(err_q, 32'h1);
		$display("register gate test done");
	endtask
	task automatic t_pwr;
		wr(12'h004, 32'h80);
		wr(12'h000, 32'hFFFFFFFF);
		rdc(12'h000, 32'h80);
		sub <= 1'b1;
		@(negedge pclk);
		check(flash_pd, 32'h0);
		wr(12'h000, 32'h0);
		@(negedge pclk);
		check(flash_pd, 32'h1);
		$display("power-down test done");
	endtask
	task automatic t_modes;
		logic [7:0] tbl [4] = '{8'h5D, 8'h3E, 8'hE3, 8'h88};
		foreach (tbl[i]) begin
			strap <= tbl[i][7:2];
			do_reset(20);
			@(negedge pclk);
			check(mode_sel, tbl[i][1:0]);
		end
		$display("strap mode test done");
	endtask
	task automatic t_boot;
		// Reply, length 3, program; a real program first sets its stack
		logic [7:0] msg [6] = '{8'h55, 8'h00, 8'h03, 8'hA1, 8'hB2, 8'hC3};
		int k;
		sub <= 1'b0;
		strap <= 6'h0F;
		raddr <= 11'h001;
		do_reset(20);
		k = 0;
		while (fbmc_host_model_i.n_rx == 0 && k < 40) begin
			fbmc_host_model_i.send(8'h00);
			k++;
		end
		if (k >= 40) give_up;
		check(fbmc_host_model_i.rx_byte, 32'h0);
		// Bad indication: host restarts boot by reset, run is spoiled
		if (fbmc_host_model_i.rx_byte !== 8'h00) begin
			do_reset(20);
			give_up;
		end
		check(32'(baud == 16'h40 || baud == 16'h3F), 32'h1);
		foreach (msg[i]) fbmc_host_model_i.send(msg[i]);
		k = 0;
		while (erase_req !== 1'b1 && k < 500) begin
			@(posedge pclk);
			k++;
		end
		if (k >= 500) give_up;
		@(negedge pclk);
		check(exec_start, 32'h0);
		check(locked, 32'h1);
		check(ram_q, 32'h0);
		@(posedge pclk);
		edone <= 1'b1;
		@(posedge pclk);
		edone <= 1'b0;
		k = 0;
		while (exec_start !== 1'b1 && k < 500) begin
			@(posedge pclk);
			k++;
		end
		if (k >= 500) give_up;
		repeat (2) @(negedge pclk);
		check(ram_q, 32'hB2);
		check({locked, rx_en, tx_on, txd}, 32'h1);
		@(posedge pclk);
		wdog <= 1'b1;
		@(posedge pclk);
		wdog <= 1'b0;
		@(negedge pclk);
		check(mode_sel, 32'h0);
		$display("boot load test done");
	endtask
	// Main sequence
	initial begin
		do_reset(4);
		t_regs;
		t_pwr;
		t_modes;
		t_boot;
		complete_run;
	end
endmodule // fbmc_top_tb
`default_nettype wire
